// file: shared/dao_pkg.sv
// shared types and constants for the device access ordering unit
package dao_pkg;
    // interface indices
    localparam int unsigned NUM_IF  = 4;
    localparam logic [1:0]  IF_MAIN = 2'h0;
    localparam logic [1:0]  IF_PERI = 2'h1;
    localparam logic [1:0]  IF_AHB  = 2'h2;
    localparam logic [1:0]  IF_VIRT = 2'h3;

    // transaction ids on the shared peripheral port and the main port
    localparam logic [3:0] ID_MAIN = 4'h0;
    localparam logic [3:0] ID_PERI = 4'h1;
    localparam logic [3:0] ID_VIRT = 4'h2;
    localparam logic [3:0] ID_AHB  = 4'h3;

    // outstanding write caps, differing on the two peripheral ids
    localparam int unsigned CAP_MAIN = 8;
    localparam int unsigned CAP_PERI = 4;
    localparam int unsigned CAP_AHB  = 1;
    localparam int unsigned CAP_VIRT = 2;
    localparam int unsigned CNT_W    = 4;

    localparam int unsigned ADDR_W = 32;
    localparam int unsigned DATA_W = 32;

    // core side access request
    typedef struct packed {
        logic              write;
        logic [1:0]        port;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } dao_req_t;

    // bus side issued transaction
    typedef struct packed {
        logic              write;
        logic [1:0]        port;
        logic [3:0]        id;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } dao_bus_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT_DRAIN,
        ST_READ_OUT,
        ST_READ_WAIT
    } dao_state_t;
endpackage : dao_pkg

// file: sim/dao_bus_model.sv
// behavioural interconnect partner with held and reorderable write responses
`timescale 1ns/1ps
module dao_bus_model (
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst,
    // issue side
    input  wire logic              bus_valid,
    input  wire dao_pkg::dao_bus_t bus,
    output logic                   bus_ready,
    // responses
    output logic                   wresp_valid = 1'b0,
    output logic [3:0]             wresp_id = 4'h0,
    output logic                   rresp_valid = 1'b0,
    output logic [31:0]            rresp_data = 32'h0000_0000,
    // stall controls from the bench
    input  wire logic              slow,
    input  wire logic              hold_en,
    input  wire logic [3:0]        hold_id,
    input  wire logic              lifo
);
    logic        tick_q = 1'b0;
    logic [31:0] mem [logic [31:0]];
    logic [3:0]  pend [$];
    int          k;
    // slow mode takes a transfer only every other cycle
    assign bus_ready = !slow || tick_q;
    // released lines flip each cycle so a stale value never looks valid
    always @(posedge core_clk) begin
        tick_q      <= rst ? 1'b0 : !tick_q;
        wresp_valid <= 1'b0;
        wresp_id    <= ~wresp_id;
        rresp_valid <= 1'b0;
        rresp_data  <= ~rresp_data;
        if (rst) begin
            pend.delete();
        end else begin
            // held ids wait while others overtake them
            k = -1;
            for (int j = 0; j < pend.size(); j++) begin
                if (!(hold_en && pend[j] == hold_id) && (k < 0 || lifo)) k = j;
            end
            if (k >= 0) begin
                wresp_valid <= 1'b1;
                wresp_id    <= pend[k];
                pend.delete(k);
            end
            if (bus_valid && bus_ready && bus.write) begin
                mem[bus.addr] = bus.data;
                pend.push_back(bus.id);
            end else if (bus_valid && bus_ready) begin
                rresp_valid <= 1'b1;
                rresp_data  <= mem.exists(bus.addr) ? mem[bus.addr] : 32'h0000_0000;
            end
        end
    end
endmodule : dao_bus_model

// file: sim/device_access_ordering_unit_bench.sv
// self-checking bench for the device access ordering unit
`timescale 1ns/1ps
module device_access_ordering_unit_bench;
    logic              core_clk = 1'b0;
    logic              rst = 1'b1;
    logic              req_valid = 1'b0;
    logic              barrier_req = 1'b0;
    dao_pkg::dao_req_t req = '0;
    logic              req_ready_q, barrier_done_q, rd_done_q, bus_valid_q, bus_ready;
    logic              wresp_valid, rresp_valid, seen;
    logic [31:0]       rd_data_q, rresp_data;
    dao_pkg::dao_bus_t bus_q;
    logic [3:0]        wresp_id, if_busy_q;
    logic [3:0]        hold_id = 4'h0;
    logic              slow = 1'b0;
    logic              hold_en = 1'b0;
    dao_pkg::dao_bus_t log_q [$];
    int                n_errors = 0;
    int                cmp_count = 0;

    always #12.5 core_clk = ~core_clk;

    dao_order_unit i_dao_order_unit (.core_clk(core_clk), .rst(rst), .req_valid(req_valid), .req(req),
        .barrier_req(barrier_req), .req_ready_q(req_ready_q), .barrier_done_q(barrier_done_q),
        .rd_data_q(rd_data_q), .rd_done_q(rd_done_q), .bus_valid_q(bus_valid_q), .bus_q(bus_q),
        .bus_ready(bus_ready), .wresp_valid(wresp_valid), .wresp_id(wresp_id), .rresp_valid(rresp_valid),
        .rresp_data(rresp_data), .if_busy_q(if_busy_q));
    dao_bus_model i_dao_bus_model (.core_clk(core_clk), .rst(rst), .bus_valid(bus_valid_q), .bus(bus_q),
        .bus_ready(bus_ready), .wresp_valid(wresp_valid), .wresp_id(wresp_id), .rresp_valid(rresp_valid),
        .rresp_data(rresp_data), .slow(slow), .hold_en(hold_en), .hold_id(hold_id), .lifo(1'b0));

    // log every transfer the bus takes
    always @(posedge core_clk) if (bus_valid_q && bus_ready) log_q.push_back(bus_q);

    task automatic chk(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : chk

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    // hold the request until the hint is seen, then let one edge pass
    task automatic send(input logic w, input logic [1:0] p, input logic [31:0] a, input logic [31:0] d);
        int i;
        req_valid <= 1'b1;
        req       <= '{write: w, port: p, addr: a, data: d};
        for (i = 0; i < 60; i++) begin
            @(posedge core_clk);
            if (req_ready_q === 1'b1) break;
        end
        req_valid <= 1'b0;
        chk(i < 60, "request never taken");
        if (i == 60) end_sim();
        @(posedge core_clk);
    endtask : send

    // bounded wait for a read or barrier completion pulse
    task automatic wait_pulse(input logic bar, input int lim, input logic must, output logic hit);
        hit = 1'b0;
        repeat (lim) begin
            @(posedge core_clk);
            if ((bar ? barrier_done_q : rd_done_q) === 1'b1) begin
                hit = 1'b1;
                break;
            end
        end
        if (must && !hit) begin
            chk(1'b0, "completion pulse missing");
            end_sim();
        end
    endtask : wait_pulse

    task automatic t_ids;
        logic [3:0] ids [4];
        ids = '{dao_pkg::ID_MAIN, dao_pkg::ID_PERI, dao_pkg::ID_AHB, dao_pkg::ID_VIRT};
        slow <= 1'b1;
        log_q.delete();
        for (int p = 0; p < 4; p++) begin
            send(1'b1, 2'(p), 32'h0000_0100, 32'ha5a5_0000 | 32'(p));
            send(1'b1, 2'(p), 32'h0000_0104, 32'h5a5a_0000 | 32'(p));
        end
        repeat (30) @(posedge core_clk);
        chk(log_q.size() == 8, "writes held back");
        for (int j = 0; j < 8 && j < log_q.size(); j++) begin
            chk(log_q[j].write === 1'b1 && log_q[j].id === ids[j/2] &&
                log_q[j].data === (((j % 2) ? 32'h5a5a_0000 : 32'ha5a5_0000) | 32'(j/2)), "id or order");
        end
        slow <= 1'b0;
        $display("test ids done");
    endtask : t_ids

    task automatic t_same_if;
        hold_id <= dao_pkg::ID_MAIN;
        hold_en <= 1'b1;
        send(1'b1, dao_pkg::IF_MAIN, 32'h0000_0200, 32'hc0de_0001);
        repeat (6) @(posedge core_clk);
        chk(if_busy_q[dao_pkg::IF_MAIN] === 1'b1, "main not busy");
        send(1'b0, dao_pkg::IF_PERI, 32'h0000_0200, 32'h0000_0000);
        wait_pulse(1'b0, 40, 1'b1, seen);
        log_q.delete();
        send(1'b0, dao_pkg::IF_MAIN, 32'h0000_0200, 32'h0000_0000);
        wait_pulse(1'b0, 20, 1'b0, seen);
        chk(seen === 1'b0 && log_q.size() == 0, "read passed held write");
        hold_en <= 1'b0;
        wait_pulse(1'b0, 40, 1'b1, seen);
        chk(rd_data_q === 32'hc0de_0001, "main read data");
        $display("test same interface done");
    endtask : t_same_if

    task automatic t_peri_virt;
        hold_id <= dao_pkg::ID_PERI;
        hold_en <= 1'b1;
        log_q.delete();
        send(1'b1, dao_pkg::IF_PERI, 32'h0000_0400, 32'h1111_0000);
        send(1'b1, dao_pkg::IF_VIRT, 32'h0000_0404, 32'h2222_0000);
        send(1'b0, dao_pkg::IF_VIRT, 32'h0000_0404, 32'h0000_0000);
        wait_pulse(1'b0, 40, 1'b1, seen);
        chk(rd_data_q === 32'h2222_0000, "virtual read data");
        chk(log_q[0].id === dao_pkg::ID_PERI && log_q[1].id === dao_pkg::ID_VIRT, "buffer order");
        chk(if_busy_q === 4'b0010, "busy flags");
        send(1'b0, dao_pkg::IF_PERI, 32'h0000_0400, 32'h0000_0000);
        wait_pulse(1'b0, 20, 1'b0, seen);
        chk(seen === 1'b0, "peripheral read passed write");
        hold_en <= 1'b0;
        wait_pulse(1'b0, 40, 1'b1, seen);
        chk(rd_data_q === 32'h1111_0000, "peripheral read data");
        $display("test peripheral pair done");
    endtask : t_peri_virt

    // park responses so writes pile up against each peripheral cap
    task automatic t_caps;
        int n;
        hold_id <= dao_pkg::ID_PERI;
        hold_en <= 1'b1;
        log_q.delete();
        for (int j = 0; j <= dao_pkg::CAP_PERI; j++) begin
            send(1'b1, dao_pkg::IF_PERI, 32'h0000_0600, 32'(j));
        end
        repeat (10) @(posedge core_clk);
        chk(log_q.size() == dao_pkg::CAP_PERI, "peripheral cap");
        hold_id <= dao_pkg::ID_VIRT;
        repeat (12) @(posedge core_clk);
        log_q.delete();
        for (int j = 0; j <= dao_pkg::CAP_VIRT; j++) begin
            send(1'b1, dao_pkg::IF_VIRT, 32'h0000_0700, 32'(j));
        end
        repeat (10) @(posedge core_clk);
        n = 0;
        foreach (log_q[j]) begin
            if (log_q[j].id === dao_pkg::ID_VIRT) n++;
        end
        chk(n == dao_pkg::CAP_VIRT, "virtual cap");
        hold_en <= 1'b0;
        repeat (10) @(posedge core_clk);
        chk(if_busy_q === 4'h0, "caps not drained");
        $display("test caps done");
    endtask : t_caps

    task automatic t_barrier;
        hold_id <= dao_pkg::ID_AHB;
        hold_en <= 1'b1;
        send(1'b1, dao_pkg::IF_AHB, 32'h0000_0500, 32'h3333_0000);
        barrier_req <= 1'b1;
        @(posedge core_clk);
        barrier_req <= 1'b0;
        wait_pulse(1'b1, 20, 1'b0, seen);
        chk(seen === 1'b0, "barrier ended early");
        hold_en <= 1'b0;
        wait_pulse(1'b1, 40, 1'b1, seen);
        chk(if_busy_q === 4'h0, "busy after barrier");
        $display("test barrier done");
    endtask : t_barrier

    initial begin
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        t_ids();
        t_same_if();
        t_peri_virt();
        t_caps();
        t_barrier();
        end_sim();
    end
endmodule : device_access_ordering_unit_bench

// file: src/dao_order_unit.sv
// ordering unit for device-type accesses across four bus interfaces
//
// Behaviour
// - uncached read stalls everything until complete
// - writes on one interface share one id
// - device read waits for earlier same-interface writes
// - wait covers buffered and response-pending writes
// - each interface ordered as one flat region
// - reads ignore writes on other interfaces
// - peripheral read waits peripheral writes only
// - buffered device writes drain immediately
// - barrier waits for all interfaces drained
// - main, peripheral, ahb ordered independently
// - virtual peripheral tracked apart, same port
// - distinct peripheral ids, out-of-order responses accepted
// - separate differing write caps per peripheral
// - shared peripheral write buffer drains in order
// - virtual read waits virtual writes only
`timescale 1ns/1ps
module dao_order_unit #(
    parameter int unsigned BUF_DEPTH = 4
) (
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst,
    // core request
    input  wire logic              req_valid,
    input  wire dao_pkg::dao_req_t req,
    input  wire logic              barrier_req,
    output logic                   req_ready_q,
    output logic                   barrier_done_q,
    output logic [dao_pkg::DATA_W-1:0] rd_data_q,
    output logic                   rd_done_q,
    // bus issue
    output logic                   bus_valid_q,
    output dao_pkg::dao_bus_t      bus_q,
    input  wire logic              bus_ready,
    // bus responses
    input  wire logic              wresp_valid,
    input  wire logic [3:0]        wresp_id,
    input  wire logic              rresp_valid,
    input  wire logic [dao_pkg::DATA_W-1:0] rresp_data,
    // status
    output logic [dao_pkg::NUM_IF-1:0] if_busy_q
);
    localparam int unsigned PW = $clog2(BUF_DEPTH);

    dao_pkg::dao_state_t state_q;
    dao_pkg::dao_req_t   rd_req_q;
    logic [dao_pkg::CNT_W-1:0] pend_q [dao_pkg::NUM_IF];
    dao_pkg::dao_req_t   buf_q [BUF_DEPTH];
    logic [PW-1:0]       wp_q;
    logic [PW-1:0]       rp_q;
    logic [PW:0]         cnt_q;
    logic [dao_pkg::NUM_IF-1:0] in_buf;
    logic                barrier_q;

    // id per interface: every write on a port reuses one id
    function automatic logic [3:0] id_of(input logic [1:0] p);
        case (p)
            dao_pkg::IF_MAIN: id_of = dao_pkg::ID_MAIN;
            dao_pkg::IF_PERI: id_of = dao_pkg::ID_PERI;
            dao_pkg::IF_AHB:  id_of = dao_pkg::ID_AHB;
            default:          id_of = dao_pkg::ID_VIRT;
        endcase
    endfunction : id_of

    function automatic logic [dao_pkg::CNT_W-1:0] cap_of(input logic [1:0] p);
        case (p)
            dao_pkg::IF_MAIN: cap_of = dao_pkg::CNT_W'(dao_pkg::CAP_MAIN);
            dao_pkg::IF_PERI: cap_of = dao_pkg::CNT_W'(dao_pkg::CAP_PERI);
            dao_pkg::IF_AHB:  cap_of = dao_pkg::CNT_W'(dao_pkg::CAP_AHB);
            default:          cap_of = dao_pkg::CNT_W'(dao_pkg::CAP_VIRT);
        endcase
    endfunction : cap_of

    // which interfaces still hold writes in the buffer
    always_comb begin
        in_buf = '0;
        for (int i = 0; i < BUF_DEPTH; i++) begin
            if (PW'(i - int'(rp_q)) < cnt_q[PW-1:0] || cnt_q[PW]) begin
                in_buf[buf_q[i].port] = 1'b1;
            end
        end
    end

    // interface drained: nothing buffered, nothing awaiting response
    logic [dao_pkg::NUM_IF-1:0] if_clear;
    always_comb begin
        for (int i = 0; i < dao_pkg::NUM_IF; i++) begin
            if_clear[i] = !in_buf[i] && pend_q[i] == '0;
        end
    end

    logic buf_full;
    logic buf_empty;
    logic head_issue;
    logic wr_accept;
    logic rd_accept;
    logic head_fire;
    logic rd_launch;
    dao_pkg::dao_req_t head;
    assign buf_full  = cnt_q == (PW+1)'(BUF_DEPTH);
    assign buf_empty = cnt_q == '0;
    assign head      = buf_q[rp_q];
    // head issues only when under its own interface cap
    assign head_issue = !buf_empty && pend_q[head.port] < cap_of(head.port);
    // a launching read takes the bus register; a head firing with it would be lost
    assign rd_launch = state_q == dao_pkg::ST_WAIT_DRAIN && if_clear[rd_req_q.port] && (!bus_valid_q || bus_ready);
    // read owns the bus while out, so head is suppressed then
    assign head_fire = head_issue && state_q != dao_pkg::ST_READ_OUT && !rd_launch
                       && (!bus_valid_q || bus_ready);
    // acceptance follows registered ready, which implies idle: a pending read stalls all
    assign wr_accept = req_valid && req.write && req_ready_q && !buf_full;
    assign rd_accept = req_valid && !req.write && req_ready_q;

    // write buffer, strictly first in first out across both peripheral ids
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (wr_accept) begin
                buf_q[wp_q] <= req;
                wp_q        <= wp_q + 1'b1;
            end
            if (head_fire) begin
                rp_q <= rp_q + 1'b1; // drains as soon as allowed, no merging
            end
            cnt_q <= cnt_q + (PW+1)'(wr_accept) - (PW+1)'(head_fire);
        end
    end

    // response counters per interface; set and clear may meet
    always_ff @(posedge core_clk) begin
        if (rst) begin
            for (int i = 0; i < dao_pkg::NUM_IF; i++) begin
                pend_q[i] <= '0;
            end
        end else begin
            for (int i = 0; i < dao_pkg::NUM_IF; i++) begin
                // ids looked up independently: responses may come back in any order
                pend_q[i] <= pend_q[i]
                    + dao_pkg::CNT_W'(head_fire && head.port == 2'(i))
                    - dao_pkg::CNT_W'(wresp_valid && wresp_id == id_of(2'(i)) && pend_q[i] != '0);
            end
        end
    end

    // bus output register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            bus_valid_q <= 1'b0;
            bus_q       <= '0;
        end else if (state_q == dao_pkg::ST_WAIT_DRAIN && if_clear[rd_req_q.port]
                     && (!bus_valid_q || bus_ready)) begin
            bus_valid_q <= 1'b1;
            bus_q       <= {1'b0, rd_req_q.port, id_of(rd_req_q.port), rd_req_q.addr, rd_req_q.data};
        end else if (head_fire) begin
            bus_valid_q <= 1'b1;
            bus_q       <= {1'b1, head.port, id_of(head.port), head.addr, head.data};
        end else if (bus_ready) begin
            bus_valid_q <= 1'b0;
        end
    end

    // read sequencer: waits on its own interface only
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q   <= dao_pkg::ST_IDLE;
            rd_req_q  <= '0;
            rd_data_q <= '0;
            rd_done_q <= 1'b0;
        end else begin
            rd_done_q <= 1'b0;
            case (state_q)
                dao_pkg::ST_IDLE: begin
                    if (rd_accept) begin
                        rd_req_q <= req;
                        state_q  <= dao_pkg::ST_WAIT_DRAIN;
                    end
                end
                dao_pkg::ST_WAIT_DRAIN: begin
                    if (if_clear[rd_req_q.port] && (!bus_valid_q || bus_ready)) begin
                        state_q <= dao_pkg::ST_READ_OUT;
                    end
                end
                dao_pkg::ST_READ_OUT: begin
                    if (bus_ready) begin
                        state_q <= dao_pkg::ST_READ_WAIT;
                    end
                end
                dao_pkg::ST_READ_WAIT: begin
                    if (rresp_valid) begin
                        rd_data_q <= rresp_data;
                        rd_done_q <= 1'b1;
                        state_q   <= dao_pkg::ST_IDLE;
                    end
                end
                default: state_q <= dao_pkg::ST_IDLE;
            endcase
        end
    end

    // barrier holds new accesses until every interface drains
    always_ff @(posedge core_clk) begin
        if (rst) begin
            barrier_q      <= 1'b0;
            barrier_done_q <= 1'b0;
        end else begin
            barrier_done_q <= 1'b0;
            if (barrier_req && !barrier_q && state_q == dao_pkg::ST_IDLE) begin
                barrier_q <= 1'b1;
            end else if (barrier_q && &if_clear && !bus_valid_q) begin
                barrier_q      <= 1'b0;
                barrier_done_q <= 1'b1;
            end
        end
    end

    // registered ready and status
    always_ff @(posedge core_clk) begin
        if (rst) begin
            req_ready_q <= 1'b0;
            if_busy_q   <= '0;
        end else begin
            // drops in the cycle after a read is taken, so no second request slips in
            req_ready_q <= state_q == dao_pkg::ST_IDLE && !rd_accept && !barrier_q && !barrier_req
                           && cnt_q < (PW+1)'(BUF_DEPTH - 1);
            if_busy_q   <= ~if_clear;
        end
    end

    // a read is only on the bus after its interface has drained
    a_read_after_drain: assert property (@(posedge core_clk) disable iff (rst)
        $rose(state_q == dao_pkg::ST_READ_OUT) |-> $past(if_clear[rd_req_q.port]))
        else $error("read issued with writes pending on its interface");
    // no writes enter while a read is in flight
    a_read_blocks_all: assert property (@(posedge core_clk) disable iff (rst)
        state_q != dao_pkg::ST_IDLE |-> !wr_accept)
        else $error("access accepted behind a pending read");
    // written id matches its interface
    a_write_same_id: assert property (@(posedge core_clk) disable iff (rst)
        bus_valid_q && bus_q.write |-> bus_q.id == id_of(bus_q.port))
        else $error("write issued with wrong id");
    // peripheral and virtual peripheral caps never exceeded
    a_write_cap: assert property (@(posedge core_clk) disable iff (rst)
        pend_q[dao_pkg::IF_VIRT] <= dao_pkg::CNT_W'(dao_pkg::CAP_VIRT)
        && pend_q[dao_pkg::IF_PERI] <= dao_pkg::CNT_W'(dao_pkg::CAP_PERI))
        else $error("peripheral write cap exceeded");
    // in-order drain of the buffer
    a_fifo_order: assert property (@(posedge core_clk) disable iff (rst)
        head_fire |=> rp_q == $past(rp_q) + 1'b1)
        else $error("buffer drained out of order");
    // eligible head does not linger
    a_prompt_drain: assert property (@(posedge core_clk) disable iff (rst)
        head_issue && state_q == dao_pkg::ST_IDLE && !bus_valid_q |-> head_fire)
        else $error("buffered write held back");
    // barrier release only once all drained
    a_barrier_drain: assert property (@(posedge core_clk) disable iff (rst)
        $rose(barrier_done_q) |-> $past(&if_clear))
        else $error("barrier released early");
    // main response count rises by one on issue from the buffer head with no completion that cycle
    a_pend_track: assert property (@(posedge core_clk) disable iff (rst)
        head_fire && head.port == dao_pkg::IF_MAIN && !wresp_valid
        |=> pend_q[dao_pkg::IF_MAIN] == $past(pend_q[dao_pkg::IF_MAIN]) + 1'b1)
        else $error("pending count not incremented");
endmodule : dao_order_unit
